// ---- hdl/port_abc_pin_function_mux.sv ----
// pin-function multiplexer for ports a, b, c, plus the port d high byte selection
// assumes pins are synchronous; pads resolve out/oe outside
// What this block does
// - unselected port a/b/c pins are plain bidirectional port bits
// - porta_alt_config bit 0 routes pin a0 to external irq zero
// - irq zero edge triggered when its trigger type is 1, else level
// - porta_alt_config bit 1 routes pin a1 to irq one, same triggering
// - slave fifo mode: pin a2 is fifo read output enable, polarity bit 4
// - pin a3 is second wake input when wake bit 7 is set and oe bit 3 is clear
// - suspended with wake enabled: pin transition restarts and interrupts
// - enabled wake pin held asserted blocks suspend entry
// - slave fifo mode: pins a4, a5 are input fifo select bits
// - slave fifo mode: pin a6 is packet commit, polarity bit 5
// - pin a7 is port bit, fifo status flag or fifo chip select
// - inactive chip select masks all other slave fifo enables and strobes
// - fifo or waveform mode: port b is fifo data bus low byte
// - port c bits 0..2 drive waveform address when configured
// - port c bits 3..7 likewise drive waveform address bits
// - port d is data high byte only in fifo/waveform mode and word wide
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module port_abc_pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // configuration bits
    input wire logic [1:0] interface_mode_config_i,
    input wire logic [7:0] porta_alt_config_i,
    input wire logic [7:0] portc_alt_config_i,
    input wire logic [7:0] fifo_pin_polarity_i,
    input wire logic [7:0] wakeup_config_i,
    input wire logic [7:0] endpoint_fifo_config_i,
    input wire logic irq_zero_trigger_type_i,
    input wire logic irq_one_trigger_type_i,
    input wire logic suspended_i,
    // general-purpose port registers from the core
    input wire logic [WIDTH-1:0] porta_out_i,
    input wire logic [WIDTH-1:0] porta_output_enable_i,
    input wire logic [WIDTH-1:0] portb_out_i,
    input wire logic [WIDTH-1:0] portb_oe_i,
    input wire logic [WIDTH-1:0] portc_out_i,
    input wire logic [WIDTH-1:0] portc_oe_i,
    output logic [WIDTH-1:0] porta_in_o,
    output logic [WIDTH-1:0] portb_in_o,
    output logic [WIDTH-1:0] portc_in_o,
    // fifo / waveform engine side
    input wire logic [WIDTH-1:0] fifo_data_out_i,
    input wire logic fifo_data_drive_i,
    input wire logic fifo_status_flag_four_i,
    input wire logic [WIDTH-1:0] waveform_addr_out_i,
    output logic [WIDTH-1:0] fifo_data_bus_o,
    output fifo_ctrl_t fifo_ctrl_o,
    output logic fifo_mode_o,
    output logic data_wide_o,
    // interrupt and wake
    output logic irq_zero_req_o,
    output logic irq_one_req_o,
    output logic wake_request_o,
    output logic suspend_inhibit_o,
    // pads
    input wire logic [WIDTH-1:0] pa_pin_i,
    output logic [WIDTH-1:0] pa_pin_o,
    output logic [WIDTH-1:0] pa_pin_oe_o,
    input wire logic [WIDTH-1:0] pb_pin_i,
    output logic [WIDTH-1:0] pb_pin_o,
    output logic [WIDTH-1:0] pb_pin_oe_o,
    input wire logic [WIDTH-1:0] pc_pin_i,
    output logic [WIDTH-1:0] pc_pin_o,
    output logic [WIDTH-1:0] pc_pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    logic slave_fifo;
    logic bus_mode;
    logic irq0_sel;
    logic irq1_sel;
    logic wake_sel;
    logic flag_sel;
    logic cs_sel;
    logic wake_active;
    logic [WIDTH-1:0] a_alt;

    assign slave_fifo = interface_mode_config_i == `IFM_SLAVE_FIFO;
    assign bus_mode = interface_mode_config_i[1];
    assign irq0_sel = porta_alt_config_i[`PORTA_CFG_IRQ0];
    assign irq1_sel = porta_alt_config_i[`PORTA_CFG_IRQ1];
    // wake input needs the pin select bit and the pin left undriven
    assign wake_sel = wakeup_config_i[`WAKE_PIN_SELECT]
        & ~porta_output_enable_i[`PORTA_OE_WAKE];
    assign wake_active = wake_sel & wakeup_config_i[`WAKE_ENABLE];
    // chip select wins over the flag when both would apply
    assign cs_sel = slave_fifo & porta_alt_config_i[`PORTA_CFG_FLAG];
    assign flag_sel = ~cs_sel & (slave_fifo | bus_mode)
        & porta_alt_config_i[`PORTA_CFG_FLAG];
    assign fifo_mode_o = slave_fifo;
    // port d is not muxed here, only its selection
    assign data_wide_o = bus_mode
        & endpoint_fifo_config_i[`EP_FIFO_WORDWIDE];

    always_comb begin
        a_alt = '0;
        a_alt[0] = irq0_sel;
        a_alt[1] = irq1_sel;
        a_alt[2] = slave_fifo;
        a_alt[3] = wake_sel;
        a_alt[4] = slave_fifo;
        a_alt[5] = slave_fifo;
        a_alt[6] = slave_fifo;
        a_alt[7] = cs_sel | flag_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    // pad drive: alternate inputs never drive, flag and buses do
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_pins
            always_comb begin
                pa_pin_o[i] = porta_out_i[i];
                pa_pin_oe_o[i] = porta_output_enable_i[i] & ~a_alt[i];
                if (i == 7 && flag_sel) begin
                    pa_pin_o[i] = fifo_status_flag_four_i;
                    pa_pin_oe_o[i] = 1'b1;
                end
                if (bus_mode) begin
                    pb_pin_o[i] = fifo_data_out_i[i];
                    pb_pin_oe_o[i] = fifo_data_drive_i;
                end else begin
                    pb_pin_o[i] = portb_out_i[i];
                    pb_pin_oe_o[i] = portb_oe_i[i];
                end
                if (portc_alt_config_i[i]) begin
                    pc_pin_o[i] = waveform_addr_out_i[i];
                    pc_pin_oe_o[i] = 1'b1;
                end else begin
                    pc_pin_o[i] = portc_out_i[i];
                    pc_pin_oe_o[i] = portc_oe_i[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registered input capture
    fifo_ctrl_t next_ctrl;
    logic [WIDTH-1:0] next_fifo_data;

    always_comb begin
        next_ctrl = '0;
        next_fifo_data = bus_mode ? pb_pin_i : '0;
        if (slave_fifo) begin
            // chip select defaults active when not selected on the pin
            next_ctrl.chip_sel = cs_sel ? ~pa_pin_i[7] : 1'b1;
            if (next_ctrl.chip_sel) begin
                next_ctrl.read_oe = pa_pin_i[2]
                    ~^ fifo_pin_polarity_i[`POL_FIFO_OE];
                next_ctrl.select = pa_pin_i[5:4];
                next_ctrl.commit = pa_pin_i[6]
                    ~^ fifo_pin_polarity_i[`POL_PKT_COMMIT];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fifo_ctrl_o <= '0;
            fifo_data_bus_o <= `PORT_RESET;
            porta_in_o <= `PORT_RESET;
            portb_in_o <= `PORT_RESET;
            portc_in_o <= `PORT_RESET;
        end else begin
            fifo_ctrl_o <= next_ctrl;
            fifo_data_bus_o <= next_fifo_data;
            porta_in_o <= pa_pin_i;
            portb_in_o <= pb_pin_i;
            portc_in_o <= pc_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt and wake helpers
    irq_sense u_irq_zero (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .enable_i(irq0_sel),
        .trigger_type_i(irq_zero_trigger_type_i),
        .irq_n_i(pa_pin_i[0]),
        .request_o(irq_zero_req_o)
    );

    irq_sense u_irq_one (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .enable_i(irq1_sel),
        .trigger_type_i(irq_one_trigger_type_i),
        .irq_n_i(pa_pin_i[1]),
        .request_o(irq_one_req_o)
    );

    wake_detect u_wake (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .active_i(wake_active),
        .polarity_i(wakeup_config_i[`WAKE_POLARITY]),
        .suspended_i(suspended_i),
        .pin_i(pa_pin_i[3]),
        .wake_request_o(wake_request_o),
        .inhibit_o(suspend_inhibit_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_irq0_level;
        @(posedge core_clk_i) disable iff (rst_i)
        (irq0_sel && !irq_zero_trigger_type_i && !pa_pin_i[0])
            |=> irq_zero_req_o;
    endproperty
    a_irq0_level: assert property (p_irq0_level)
        else $error("irq0 level");

    property p_irq1_off;
        @(posedge core_clk_i) disable iff (rst_i)
        !irq1_sel |=> !irq_one_req_o;
    endproperty
    a_irq1_off: assert property (p_irq1_off)
        else $error("irq1 unselected");

    property p_a_inputs;
        @(posedge core_clk_i) disable iff (rst_i)
        slave_fifo |-> (pa_pin_oe_o[6:4] == 3'h0) && !pa_pin_oe_o[2];
    endproperty
    a_a_inputs: assert property (p_a_inputs)
        else $error("fifo input driven");

    property p_oe_pol;
        @(posedge core_clk_i) disable iff (rst_i)
        (slave_fifo && !cs_sel) |=> fifo_ctrl_o.read_oe
            == ($past(pa_pin_i[2]) ~^ $past(fifo_pin_polarity_i[4]));
    endproperty
    a_oe_pol: assert property (p_oe_pol)
        else $error("read oe polarity");

    property p_commit_pol;
        @(posedge core_clk_i) disable iff (rst_i)
        (slave_fifo && !cs_sel) |=> fifo_ctrl_o.commit
            == ($past(pa_pin_i[6]) ~^ $past(fifo_pin_polarity_i[5]));
    endproperty
    a_commit_pol: assert property (p_commit_pol)
        else $error("commit pol");

    property p_cs_gate;
        @(posedge core_clk_i) disable iff (rst_i)
        (cs_sel && pa_pin_i[7]) |=> (fifo_ctrl_o == '0);
    endproperty
    a_cs_gate: assert property (p_cs_gate)
        else $error("cs not gating");

    property p_flag_out;
        @(posedge core_clk_i) disable iff (rst_i)
        flag_sel |-> pa_pin_oe_o[7] && pa_pin_o[7] == fifo_status_flag_four_i;
    endproperty
    a_flag_out: assert property (p_flag_out)
        else $error("flag not driven");

    property p_portb_bus;
        @(posedge core_clk_i) disable iff (rst_i)
        bus_mode |-> pb_pin_oe_o == {WIDTH{fifo_data_drive_i}}
            && pb_pin_o == fifo_data_out_i;
    endproperty
    a_portb_bus: assert property (p_portb_bus)
        else $error("port b bus");

    property p_portc_addr;
        @(posedge core_clk_i) disable iff (rst_i)
        ((pc_pin_o & portc_alt_config_i)
            == (waveform_addr_out_i & portc_alt_config_i))
            && ((pc_pin_oe_o & portc_alt_config_i) == portc_alt_config_i);
    endproperty
    a_portc_addr: assert property (p_portc_addr)
        else $error("port c addr");

    property p_wide;
        @(posedge core_clk_i) disable iff (rst_i)
        data_wide_o |-> interface_mode_config_i[1]
            && endpoint_fifo_config_i[0];
    endproperty
    a_wide: assert property (p_wide) else $error("wide select");

    property p_inhibit;
        @(posedge core_clk_i) disable iff (rst_i)
        (wake_active && (pa_pin_i[3] == wakeup_config_i[4]))
            |-> suspend_inhibit_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("no inhibit");

    property p_reset_in;
        @(posedge core_clk_i)
        $fell(rst_i) |-> !fifo_ctrl_o.chip_sel && !irq_zero_req_o;
    endproperty
    a_reset_in: assert property (p_reset_in)
        else $error("reset state");

    c_slave: cover property (@(posedge core_clk_i) disable iff (rst_i)
        slave_fifo && fifo_ctrl_o.commit);
    c_cs_block: cover property (@(posedge core_clk_i) disable iff (rst_i)
        cs_sel && pa_pin_i[7]);
    c_waveform: cover property (@(posedge core_clk_i) disable iff (rst_i)
        portc_alt_config_i == 8'hff && bus_mode);

endmodule : port_abc_pin_function_mux

// ---- hdl/pin_mux_defs.svh ----
// constants for the port a/b/c pin-function multiplexer
// assumes inclusion by bare name from the design files
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// interface_mode_config[1:0] encodings
`define IFM_PORTS 2'h0
`define IFM_RESERVED 2'h1
`define IFM_WAVEFORM 2'h2
`define IFM_SLAVE_FIFO 2'h3
// bit positions
`define PORTA_CFG_IRQ0 0
`define PORTA_CFG_IRQ1 1
`define PORTA_CFG_FLAG 7
`define POL_FIFO_OE 4
`define POL_PKT_COMMIT 5
`define WAKE_ENABLE 1
`define WAKE_POLARITY 4
`define WAKE_PIN_SELECT 7
`define PORTA_OE_WAKE 3
`define EP_FIFO_WORDWIDE 0
// reset values
`define PORT_RESET 8'h00

`endif

// ---- hdl/pin_mux_pkg.sv ----
// types shared by the pin multiplexer files
// assumes the constants header for field positions
package pin_mux_pkg;

    // per-port pin triple as seen by a design port
    typedef struct packed {
        logic [7:0] in;
        logic [7:0] out;
        logic [7:0] oe;
    } port_pins_t;

    // decoded slave-fifo inputs after polarity and chip-select gating
    typedef struct packed {
        logic read_oe;
        logic [1:0] select;
        logic commit;
        logic chip_sel;
    } fifo_ctrl_t;

    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_ARMED,
        WAKE_FIRED
    } wake_state_t;

endpackage : pin_mux_pkg

// ---- hdl/irq_sense.sv ----
// one external interrupt input, edge or level sensed
// assumes the pin is already synchronous to core_clk_i
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module irq_sense (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic trigger_type_i,
    input wire logic irq_n_i,
    // request
    output logic request_o
);
    logic last_n;
    logic next_last_n;
    logic next_request;

    always_comb begin
        next_last_n = enable_i ? irq_n_i : 1'b1;
        next_request = 1'b0;
        if (enable_i) begin
            if (trigger_type_i) begin
                // falling edge only
                next_request = last_n & ~irq_n_i;
            end else begin
                next_request = ~irq_n_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_n <= 1'b1;
            request_o <= 1'b0;
        end else begin
            last_n <= next_last_n;
            request_o <= next_request;
        end
    end

    property p_edge_req;
        @(posedge core_clk_i) disable iff (rst_i)
        (enable_i && trigger_type_i && last_n && !irq_n_i) |=> request_o;
    endproperty
    a_edge_req: assert property (p_edge_req)
        else $error("edge irq lost");

    property p_edge_once;
        @(posedge core_clk_i) disable iff (rst_i)
        (trigger_type_i && $stable(trigger_type_i) && $past(enable_i)
            && !$past(irq_n_i) && !irq_n_i) |=> !request_o;
    endproperty
    a_edge_once: assert property (p_edge_once)
        else $error("edge repeated");

    c_level: cover property (@(posedge core_clk_i) disable iff (rst_i)
        !trigger_type_i && request_o);
endmodule : irq_sense

// ---- hdl/wake_detect.sv ----
// second wake source: pin transition detect and suspend inhibit
// assumes suspended_i is a level from the power controller
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module wake_detect
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control
    input wire logic active_i,
    input wire logic polarity_i,
    input wire logic suspended_i,
    input wire logic pin_i,
    // results
    output logic wake_request_o,
    output logic inhibit_o
);
    wake_state_t state;
    wake_state_t next_state;
    logic last_pin;
    logic next_last_pin;
    logic next_wake;
    logic asserted;

    assign asserted = pin_i ^ ~polarity_i;
    // inhibit is combinational so suspend entry sees it at once
    assign inhibit_o = active_i & asserted;

    always_comb begin
        next_state = state;
        next_wake = 1'b0;
        next_last_pin = pin_i;
        case (state)
            WAKE_IDLE: begin
                if (active_i && suspended_i) begin
                    next_state = WAKE_ARMED;
                end
            end
            WAKE_ARMED: begin
                if (!active_i || !suspended_i) begin
                    next_state = WAKE_IDLE;
                end else if (pin_i != last_pin) begin
                    next_state = WAKE_FIRED;
                    next_wake = 1'b1;
                end
            end
            WAKE_FIRED: begin
                if (!suspended_i) begin
                    next_state = WAKE_IDLE;
                end
            end
            default: next_state = WAKE_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= WAKE_IDLE;
            last_pin <= 1'b0;
            wake_request_o <= 1'b0;
        end else begin
            state <= next_state;
            last_pin <= next_last_pin;
            wake_request_o <= next_wake;
        end
    end

    property p_wake;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == WAKE_ARMED && active_i && suspended_i && $changed(pin_i))
            |=> wake_request_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");

    property p_no_wake_awake;
        @(posedge core_clk_i) disable iff (rst_i)
        !$past(suspended_i) |-> !wake_request_o;
    endproperty
    a_no_wake_awake: assert property (p_no_wake_awake)
        else $error("wake while awake");

    c_wake: cover property (@(posedge core_clk_i) disable iff (rst_i)
        wake_request_o);
endmodule : wake_detect

// ---- tb/fifo_master_model.sv ----
// far-side model: external fifo master plus plain pin drivers
// assumes device pads win wherever the device drives a pin
`timescale 1ns/1ps
module fifo_master_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // fifo master controls, active high
    input wire logic master_i,
    input wire logic read_oe_i,
    input wire logic [1:0] select_i,
    input wire logic commit_i,
    input wire logic chip_sel_i,
    input wire logic oe_pol_i,
    input wire logic commit_pol_i,
    // plain pin drive, {c, b, a}
    input wire logic [23:0] val_i,
    input wire logic [23:0] en_i,
    // device pads
    input wire logic [23:0] dev_o_i,
    input wire logic [23:0] dev_oe_i,
    // resolved pin levels
    output logic [23:0] wire_o
);
    logic [7:0] noise;
    logic [23:0] drv;
    logic [23:0] den;
    ////////////////////////////////////////////////////////////////////////
    // floating pins read a counter stepped by 8'h5b each cycle; only bit 0 toggles every cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            noise <= 8'h00;
        end else begin
            noise <= noise + 8'h5b;
        end
    end
    always_comb begin
        drv = val_i;
        den = en_i;
        if (master_i) begin
            den[7:2] = 6'h3d; // a3 stays free: not a fifo pin
            drv[2] = read_oe_i ~^ oe_pol_i;
            drv[5:4] = select_i;
            drv[6] = commit_i ~^ commit_pol_i;
            drv[7] = ~chip_sel_i;
        end
        for (int i = 0; i < 24; i++) begin
            wire_o[i] = dev_oe_i[i] ? dev_o_i[i] :
                den[i] ? drv[i] : noise[i % 8];
        end
    end
endmodule : fifo_master_model

// ---- tb/port_abc_pin_function_mux_tb.sv ----
// self-checking bench for the port a/b/c pin-function multiplexer
// assumes the far side is the fifo master model, one core clock
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module port_abc_pin_function_mux_tb
    import pin_mux_pkg::*;
;
    logic core_clk_i, rst_i;
    logic [1:0] mode, m_sel;
    logic [7:0] pa_cfg, pc_cfg, pol, wk_cfg, ep_cfg;
    logic trig0, trig1, susp, fd_drive, flag4;
    logic mst, m_oe, m_com, m_cs;
    logic [7:0] a_out, a_oe, b_out, b_oe, c_out, c_oe, fd_out, wf_addr;
    logic [7:0] pa_in, pb_in, pc_in, fd_bus;
    logic [7:0] pa_o, pa_e, pb_o, pb_e, pc_o, pc_e;
    fifo_ctrl_t fctl;
    logic fmode, dwide, irq0, irq1, wake, inhib;
    logic [23:0] ext_val, ext_en, wires;
    logic [15:0] e;
    int mismatches, cmp_count, cycles;

    port_abc_pin_function_mux port_abc_pin_function_mux_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .interface_mode_config_i(mode), .porta_alt_config_i(pa_cfg),
        .portc_alt_config_i(pc_cfg), .fifo_pin_polarity_i(pol),
        .wakeup_config_i(wk_cfg), .endpoint_fifo_config_i(ep_cfg),
        .irq_zero_trigger_type_i(trig0), .irq_one_trigger_type_i(trig1),
        .suspended_i(susp), .porta_out_i(a_out),
        .porta_output_enable_i(a_oe), .portb_out_i(b_out),
        .portb_oe_i(b_oe), .portc_out_i(c_out), .portc_oe_i(c_oe),
        .porta_in_o(pa_in), .portb_in_o(pb_in), .portc_in_o(pc_in),
        .fifo_data_out_i(fd_out), .fifo_data_drive_i(fd_drive),
        .fifo_status_flag_four_i(flag4), .waveform_addr_out_i(wf_addr),
        .fifo_data_bus_o(fd_bus), .fifo_ctrl_o(fctl), .fifo_mode_o(fmode),
        .data_wide_o(dwide), .irq_zero_req_o(irq0), .irq_one_req_o(irq1),
        .wake_request_o(wake), .suspend_inhibit_o(inhib),
        .pa_pin_i(wires[7:0]), .pa_pin_o(pa_o), .pa_pin_oe_o(pa_e),
        .pb_pin_i(wires[15:8]), .pb_pin_o(pb_o), .pb_pin_oe_o(pb_e),
        .pc_pin_i(wires[23:16]), .pc_pin_o(pc_o), .pc_pin_oe_o(pc_e));

    fifo_master_model fifo_master_model_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .master_i(mst),
        .read_oe_i(m_oe), .select_i(m_sel), .commit_i(m_com),
        .chip_sel_i(m_cs), .oe_pol_i(pol[`POL_FIFO_OE]),
        .commit_pol_i(pol[`POL_PKT_COMMIT]), .val_i(ext_val),
        .en_i(ext_en), .dev_o_i({pc_o, pb_o, pa_o}),
        .dev_oe_i({pc_e, pb_e, pa_e}), .wire_o(wires));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // hang guard: the whole sequence needs about 120 cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cyc
    task automatic see(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : see
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // level mode holds the request, edge mode gives one pulse
    task automatic irq_case(input int idx, input logic trig);
        logic [15:0] x;
        x = 16'h1 << idx;
        cyc(1);
        pa_cfg <= 8'h01 << idx;
        {trig1, trig0} <= {trig, trig};
        {ext_en, ext_val} <= {24'h3, 24'h3};
        cyc(2);
        ext_val <= 24'h0;
        see(1);
        chk("irq_req", x, {14'h0, irq1, irq0});
        see(1);
        chk("irq_hold", trig ? 16'h0 : x, {14'h0, irq1, irq0});
        cyc(1);
        ext_val <= 24'h3;
    endtask : irq_case
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {mode, pa_cfg, pc_cfg, pol, wk_cfg, ep_cfg} = 42'h0;
        {trig0, trig1, susp, fd_drive, flag4} = 5'h0;
        {a_out, a_oe, b_out, b_oe, c_out, c_oe, fd_out, wf_addr} = 64'h0;
        {mst, m_oe, m_com, m_cs, m_sel} = 6'h0;
        {ext_val, ext_en} = 48'h0;
        rst_i = 1'b1;
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        see(2);
        chk("pad_oe", 16'h0, {pa_e, pb_e | pc_e});
        chk("regs", 16'h0, {9'h0, fctl, irq0, irq1});
        cyc(1);
        {a_out, a_oe, b_out, b_oe} <= 32'h5af0_110f;
        {ext_en, ext_val} <= {24'hfff00f, 24'h96c009};
        see(1);
        chk("pa_in", 16'h59, {8'h0, pa_in});
        chk("pb_in", 16'hc1, {8'h0, pb_in});
        chk("pc_in", 16'h96, {8'h0, pc_in});
        chk("pa_pad", 16'hf050, {pa_e, pa_o & 8'hf0});
        for (int i = 0; i < 4; i++) begin
            irq_case(i % 2, i[1]);
        end
        cyc(1);
        {mode, pa_cfg, a_oe, ext_en} <= {`IFM_SLAVE_FIFO, 16'h8000, 24'h0};
        mst <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            pol <= {2'h0, {2{i[2]}}, 4'h0};
            {m_oe, m_sel, m_com, m_cs} <= {i[0], i[1:0], ~i[0], 1'b1};
            see(1);
            e = {11'h0, i[0], i[1:0], ~i[0], 1'b1};
            chk("fctl", e, {11'h0, fctl});
            cyc(1);
            m_cs <= 1'b0;
            see(1);
            chk("fctl_cs", 16'h0, {11'h0, fctl});
        end
        chk("fifo_pins", 16'h1, {9'h0, pa_e[7:2], fmode});
        cyc(1);
        {mst, mode, flag4} <= {1'b0, `IFM_WAVEFORM, 1'b1};
        see(1);
        chk("flag_hi", 16'h3, {14'h0, pa_e[7], pa_o[7]});
        cyc(1);
        flag4 <= 1'b0;
        see(1);
        chk("flag_lo", 16'h2, {14'h0, pa_e[7], pa_o[7]});
        for (int m = 2; m < 4; m++) begin
            cyc(1);
            {mode, pa_cfg, b_oe, fd_drive} <= {m[1:0], 16'h00ff, 1'b0};
            {ext_en, ext_val} <= {24'h00ff00, 24'h00a500};
            see(1);
            chk("fd_in", 16'h00a5, {pb_e, fd_bus});
            cyc(1);
            {fd_drive, fd_out, ext_en} <= {1'b1, 8'h96, 24'h0};
            see(1);
            chk("fd_out", 16'hff96, {pb_e, pb_o});
        end
        cyc(1);
        {mode, b_oe} <= {`IFM_RESERVED, 8'h0f};
        see(1);
        chk("reserved", 16'h0f01, {pb_e, pb_o & 8'h0f});
        chk("fd_idle", 16'h0, {8'h0, fd_bus});
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            {pc_cfg, wf_addr, c_out} <= {i[0] ? 8'hf8 : 8'h07, 16'hc33c};
            see(1);
            e = {pc_cfg, 8'hc3 & pc_cfg};
            chk("pc_addr", e, {pc_e, pc_o & pc_cfg});
        end
        for (int m = 0; m < 8; m++) begin
            cyc(1);
            {mode, ep_cfg} <= {m[1:0], 7'h0, m[2]};
            see(1);
            chk("wide", {15'h0, m[1] & m[2]}, {15'h0, dwide});
        end
        cyc(1);
        {mode, pa_cfg, pc_cfg, a_oe, wk_cfg} <= {26'h0, 8'h92};
        {ext_en, ext_val} <= {24'h8, 24'h8};
        see(1);
        chk("inhibit", 16'h1, {15'h0, inhib});
        cyc(1);
        wk_cfg <= 8'h90;
        see(1);
        chk("inhibit_off", 16'h0, {15'h0, inhib});
        cyc(1);
        {wk_cfg, a_oe} <= {8'h92, 8'h08};
        see(1);
        chk("inhibit_oe", 16'h0, {15'h0, inhib});
        cyc(1);
        {wk_cfg, a_oe, ext_val, susp} <= {8'h92, 8'h0, 24'h0, 1'b1};
        cyc(2);
        ext_val <= 24'h8;
        for (int k = 0; k < 6; k++) begin
            see(1);
            if (wake === 1'b1) break;
        end
        chk("wake", 16'h1, {15'h0, wake});
        see(1);
        chk("wake_pulse", 16'h0, {15'h0, wake});
        cyc(1);
        rst_i <= 1'b1;
        see(1);
        chk("rst_regs", 16'h0, {8'h0, fd_bus | {fctl, irq0, irq1, wake}});
        cyc(1);
        rst_i <= 1'b0;
        cyc(2);
        complete_run();
    end
endmodule : port_abc_pin_function_mux_tb
